// ### scw_consts.svh
// timing constants for the scan cycle watchdog
`ifndef SCW_CONSTS_SVH
`define SCW_CONSTS_SVH
`define SCW_CLK_HZ 50000000
`define SCW_FATAL_CODE 8'h9F
`define SCW_EXTEND_OPCODE 8'h94
`define SCW_LONG_CYCLE_MS 100
`define SCW_CEILING_MS 6500
`define SCW_EDIT_MAX_MS 260
`define SCW_OVERSEE_US 700
`define SCW_IO_GROUP_US 20
`define SCW_PERIPH_MIN_US 260
`define SCW_PERIPH_PCT 5
`define SCW_REMOTE_MASTER_US 1100
`define SCW_SLAVE_WORD_US 170
`define SCW_US_CYCLES (`SCW_CLK_HZ / 1000000)
`define SCW_MS_US 1000
`define SCW_DEF_LIMIT_MS 130
`endif

// ### scw_pkg.sv
// types for the scan cycle watchdog
package scw_pkg;
  typedef enum logic [3:0] {
    SCW_OVERSEE = 4'h1,
    SCW_RUN = 4'h2,
    SCW_EDIT = 4'h4,
    SCW_HALT = 4'h8
  } scw_state_type;
endpackage : scw_pkg

// ### scw_tick.sv
// microsecond and millisecond tick divider
`timescale 1ns/10ps
`include "scw_consts.svh"
module scw_tick #(
  parameter int unsigned US_CYCLES = `SCW_US_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // restart the divider
  input wire logic clear_in,
  // ticks
  output logic us_tick_out,
  output logic ms_tick_out
);
  logic [7:0] div_q;
  logic [9:0] us_q;
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || clear_in) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(US_CYCLES - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || clear_in) begin
      us_q <= 10'h000;
    end else if (div_q == 8'(US_CYCLES - 1)) begin
      us_q <= (us_q == 10'(`SCW_MS_US - 1)) ? 10'h000 : us_q + 10'h001;
    end
  end
  assign us_tick_out = (div_q == 8'(US_CYCLES - 1));
  assign ms_tick_out = us_tick_out && (us_q == 10'(`SCW_MS_US - 1));
endmodule : scw_tick

// ### scw_top.sv
// scan cycle watchdog: cycle timing, limits and online edit suspension
// Summary of operation
// - each cycle is timed and one longer than the limit raises fatal code 9F and halts.
// - executing the extension instruction 94 lengthens the limit for this cycle.
// - a cycle of 100 ms or more sets the cycle time error flag without halting.
// - a cycle reaching 6500 ms raises fatal 9F whatever extension was applied.
// - an online rewrite suspends execution for at most 260 ms with interrupts masked.
// - during the edit suspension no long cycle warning or error is raised.
// - the cycle is a fixed 0.7 ms overseeing phase plus execution, refresh and servicing.
// - basic refresh costs 20 us per eight points, 12 point units counted as 16.
// - peripheral servicing is zero with no tool attached, else max of 0.26 ms and 5 pct.
// - remote refresh adds 1.1 ms per master unit and 0.17 ms per slave word.
`timescale 1ns/10ps
`include "scw_consts.svh"
module scw_top #(
  parameter int unsigned EDIT_MS = `SCW_EDIT_MAX_MS
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // cycle control from the execution engine
  input wire logic cycle_end_in,
  input wire logic watchdog_extend_instr_in,
  input wire logic [15:0] extend_ms_in,
  input wire logic [15:0] limit_ms_in,
  // online edit request from the programming port (pins)
  input wire logic edit_req_in,
  input wire logic tool_attached_in,
  // configuration for the cycle estimate
  input wire logic [7:0] io_points8_in,
  input wire logic [7:0] io_points12_in,
  input wire logic [7:0] io_points16_in,
  input wire logic [3:0] remote_masters_in,
  input wire logic [7:0] slave_words_in,
  input wire logic [15:0] exec_us_in,
  // status
  output logic run_enable_out,
  output logic irq_mask_out,
  output logic cycle_time_error_flag_out,
  output logic fatal_alarm_out,
  output logic [7:0] fatal_code_out,
  output logic [15:0] last_cycle_ms_out,
  output logic [23:0] est_cycle_us_out
);
  localparam int unsigned OVS_CYC = `SCW_OVERSEE_US * `SCW_US_CYCLES;
  scw_pkg::scw_state_type st_q;
  logic [15:0] ms_q;
  logic [16:0] lim_q;
  logic [15:0] ovs_q;
  logic [19:0] ed_q;
  logic edit_done_q;
  logic er_s1_q, er_s2_q, ta_s1_q, ta_s2_q;
  logic us_tick, ms_tick, restart;
  logic ceil_hit, over_lim, go_halt, go_edit;
  logic [17:0] lim_sum;
  logic [23:0] base_us, io_us, per_us;

  always_ff @(posedge ref_clk_in) begin
    er_s1_q <= nrst_in ? edit_req_in : 1'b0;
    er_s2_q <= nrst_in ? er_s1_q : 1'b0;
    ta_s1_q <= nrst_in ? tool_attached_in : 1'b0;
    ta_s2_q <= nrst_in ? ta_s1_q : 1'b0;
  end

  // overrun tests; the ceiling is kept apart so no extension can mask it
  assign ceil_hit = ms_tick &&
                    (ms_q + 16'h0001 >= 16'(`SCW_CEILING_MS));
  assign over_lim = ms_tick && ({1'b0, ms_q} + 17'h00001 > lim_q);
  assign go_halt = ceil_hit || over_lim;
  // one suspension per cycle, so a held request cannot stall execution
  assign go_edit = er_s2_q && !edit_done_q;
  // a cycle end that loses to a halt or an edit does not restart timing;
  // tick divider restarts with each cycle so ms counts align to its start
  assign restart = (st_q == scw_pkg::SCW_RUN) && cycle_end_in &&
                   !go_halt && !go_edit;
  scw_tick u_tick (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .clear_in(restart),
    .us_tick_out(us_tick),
    .ms_tick_out(ms_tick)
  );

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      st_q <= scw_pkg::SCW_OVERSEE;
    end else begin
      case (st_q)
        scw_pkg::SCW_OVERSEE: begin
          if (ovs_q == 16'(OVS_CYC - 1)) begin
            st_q <= scw_pkg::SCW_RUN;
          end
        end
        scw_pkg::SCW_RUN: begin
          if (go_halt) begin
            st_q <= scw_pkg::SCW_HALT;
          end else if (go_edit) begin
            st_q <= scw_pkg::SCW_EDIT;
          end else if (cycle_end_in) begin
            st_q <= scw_pkg::SCW_OVERSEE;
          end
        end
        scw_pkg::SCW_EDIT: begin
          // the clamp ends a suspension even while the request is held
          if (!er_s2_q || ed_q == 20'(EDIT_MS * `SCW_MS_US)) begin
            st_q <= scw_pkg::SCW_RUN;
          end
        end
        scw_pkg::SCW_HALT: st_q <= scw_pkg::SCW_HALT;
        default: st_q <= scw_pkg::SCW_HALT;
      endcase
    end
  end

  // overseeing phase counted in clock cycles; wide enough for the full span
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || st_q != scw_pkg::SCW_OVERSEE) begin
      ovs_q <= 16'h0000;
    end else begin
      ovs_q <= ovs_q + 16'h0001;
    end
  end

  // set by a suspension, cleared as the next cycle starts
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || restart) begin
      edit_done_q <= 1'b0;
    end else if (st_q == scw_pkg::SCW_EDIT) begin
      edit_done_q <= 1'b1;
    end
  end

  // edit time in microseconds; the cycle clock is frozen meanwhile
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || st_q != scw_pkg::SCW_EDIT) begin
      ed_q <= 20'h00000;
    end else if (us_tick && ed_q != 20'hFFFFF) begin
      ed_q <= ed_q + 20'h00001;
    end
  end

  // cycle time in ms; frozen while editing so no warning is produced
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || restart) begin
      ms_q <= 16'h0000;
    end else if (ms_tick && st_q != scw_pkg::SCW_EDIT &&
                 st_q != scw_pkg::SCW_HALT && ms_q != 16'hFFFF) begin
      ms_q <= ms_q + 16'h0001;
    end
  end

  assign lim_sum = {1'b0, lim_q} + {2'b00, extend_ms_in};
  // limit reloads each cycle; extension only widens it, ceiling still checked
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      lim_q <= 17'(`SCW_DEF_LIMIT_MS);
    end else if (restart || st_q == scw_pkg::SCW_OVERSEE) begin
      lim_q <= {1'b0, limit_ms_in};
    end else if (watchdog_extend_instr_in && st_q == scw_pkg::SCW_RUN) begin
      // saturate so repeated extensions never wrap round to a short limit
      lim_q <= lim_sum[17] ? 17'h1FFFF : lim_sum[16:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      cycle_time_error_flag_out <= 1'b0;
    end else if (st_q != scw_pkg::SCW_EDIT && ms_tick &&
                 ms_q + 16'h0001 >= 16'(`SCW_LONG_CYCLE_MS)) begin
      cycle_time_error_flag_out <= 1'b1;
    end else if (restart) begin
      cycle_time_error_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      last_cycle_ms_out <= 16'h0000;
    end else if (restart) begin
      last_cycle_ms_out <= ms_q;
    end
  end

  // alarm and code hold until reset; nothing inside the block clears them
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      fatal_alarm_out <= 1'b0;
      fatal_code_out <= 8'h00;
    end else if (st_q == scw_pkg::SCW_HALT) begin
      fatal_alarm_out <= 1'b1;
      fatal_code_out <= `SCW_FATAL_CODE;
    end
  end

  assign run_enable_out = (st_q == scw_pkg::SCW_RUN);
  assign irq_mask_out = (st_q == scw_pkg::SCW_EDIT);

  // static estimate of the cycle in microseconds
  always_comb begin
    io_us = 24'(((32'(io_points8_in) * 8 + 32'(io_points12_in) * 16 +
            32'(io_points16_in) * 16) / 8) * `SCW_IO_GROUP_US);
    io_us = io_us + 24'(32'(remote_masters_in) * `SCW_REMOTE_MASTER_US +
            32'(slave_words_in) * `SCW_SLAVE_WORD_US);
    base_us = 24'(`SCW_OVERSEE_US) + 24'(exec_us_in) + io_us;
    per_us = 24'(32'(base_us) * `SCW_PERIPH_PCT / 100);
    if (!ta_s2_q) begin
      per_us = 24'h000000;
    end else if (per_us < 24'(`SCW_PERIPH_MIN_US)) begin
      per_us = 24'(`SCW_PERIPH_MIN_US);
    end
  end

  // registered so the estimate never shows a ripple of the adders
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      est_cycle_us_out <= 24'h000000;
    end else begin
      est_cycle_us_out <= base_us + per_us;
    end
  end
endmodule : scw_top

// ### scw_top_chk.sv
// assertions for the scan cycle watchdog
`timescale 1ns/10ps
module scw_top_chk (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // observed ports
  input wire logic cycle_end_in,
  input wire logic run_enable_out,
  input wire logic irq_mask_out,
  input wire logic cycle_time_error_flag_out,
  input wire logic fatal_alarm_out,
  input wire logic [7:0] fatal_code_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_CODE: assert property (fatal_alarm_out |-> fatal_code_out == 8'h9F)
    else $error("fatal code wrong");
  AST_HALT: assert property (fatal_alarm_out |-> !run_enable_out)
    else $error("running while halted");
  AST_STICKY: assert property (fatal_alarm_out |=> fatal_alarm_out)
    else $error("alarm dropped");
  AST_EDIT_MASK: assert property (irq_mask_out |-> !run_enable_out)
    else $error("running during edit");
  AST_EDIT_FATAL: assert property (irq_mask_out |=> !$rose(fatal_alarm_out))
    else $error("alarm during edit");
  AST_EDIT_FLAG: assert property (irq_mask_out |=>
    !$rose(cycle_time_error_flag_out)) else $error("flag during edit");
  AST_END_DROP: assert property (run_enable_out && cycle_end_in
    |=> !run_enable_out) else $error("cycle end ignored");
  AST_OVERSEE: assert property ($fell(run_enable_out) && !irq_mask_out
    |=> !run_enable_out [*8]) else $error("oversee phase too short");
  cover property ($rose(fatal_alarm_out));
  cover property ($rose(irq_mask_out));
  cover property (run_enable_out && cycle_end_in);
endmodule : scw_top_chk
bind scw_top scw_top_chk u_chk (.*);

// ### scw_top_test.sv
// self-checking bench for the scan cycle watchdog
`timescale 1ns/10ps
module scw_top_test;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cycle_end_in = 1'b0;
  logic watchdog_extend_instr_in = 1'b0;
  logic edit_req_in = 1'b0;
  logic tool_attached_in = 1'b0;
  logic [15:0] extend_ms_in = 16'h0000;
  // zero limit: the first cycle outlives its first ms tick only by extension
  logic [15:0] limit_ms_in = 16'h0000;
  logic [15:0] exec_us_in = 16'h0000;
  logic [7:0] io_points8_in = 8'h00;
  logic [7:0] io_points12_in = 8'h00;
  logic [7:0] io_points16_in = 8'h00;
  logic [7:0] slave_words_in = 8'h00;
  logic [3:0] remote_masters_in = 4'h0;
  logic run_enable_out, irq_mask_out, cycle_time_error_flag_out;
  logic fatal_alarm_out;
  logic [7:0] fatal_code_out;
  logic [15:0] last_cycle_ms_out;
  logic [23:0] est_cycle_us_out;
  int n_mismatch = 0;
  int n_checks = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  // short 1 ms edit clamp; the edit below ends on release of the request, well before it
  scw_top #(.EDIT_MS(1)) u_dut (.*);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [23:0] est_exp();
    logic [23:0] r;
    logic [23:0] p;
    r = 24'h0002BC + exec_us_in + remote_masters_in * 24'h00044C
      + slave_words_in * 24'h0000AA + 24'h000014 * (io_points8_in
      + 2 * io_points12_in + 2 * io_points16_in);
    p = r * 24'h000005 / 24'h000064;
    if (!tool_attached_in) return r;
    return r + ((p > 24'h000104) ? p : 24'h000104);
  endfunction : est_exp
  task automatic chk(input string nm, input logic [23:0] e, logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // which: 0 run enable, 1 interrupt mask, 2 fatal alarm
  task automatic wait_sig(input int which, logic lvl, int lim, output int n);
    n = 0;
    while (((which == 0) ? run_enable_out : (which == 1) ?
        irq_mask_out : fatal_alarm_out) !== lvl) begin
      @(posedge ref_clk_in);
      n++;
      if (n > lim) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask : wait_sig
  initial begin
    int n;
    logic [7:0] s;
    s = 8'h1A;
    repeat (16) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    s = lfsr(s);
    io_points8_in <= {5'h00, s[2:0]};
    io_points12_in <= {5'h00, s[5:3]};
    s = lfsr(s);
    io_points16_in <= {5'h00, s[2:0]};
    remote_masters_in <= {3'h0, s[3]};
    slave_words_in <= {6'h00, s[5:4]};
    s = lfsr(s);
    exec_us_in <= {6'h00, s, s[1:0]};
    repeat (10) @(posedge ref_clk_in);
    chk("estimate", est_exp(), est_cycle_us_out);
    tool_attached_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    chk("estimate_min", est_exp(), est_cycle_us_out);
    // five percent exceeds the servicing floor here
    {io_points8_in, io_points12_in, io_points16_in} <= 24'h000000;
    {remote_masters_in, slave_words_in} <= 12'h000;
    exec_us_in <= 16'h2710;
    repeat (10) @(posedge ref_clk_in);
    chk("estimate_pct", est_exp(), est_cycle_us_out);
    $display("test estimate done");
    wait_sig(0, 1'b1, 40000, n);
    chk("oversee_len", 24'h1, {23'h0, n > 34900 && n < 35010});
    $display("test oversee done");
    edit_req_in <= 1'b1;
    wait_sig(1, 1'b1, 10, n);
    chk("edit_run", 24'h0, {23'h0, run_enable_out});
    repeat (50) @(posedge ref_clk_in);
    edit_req_in <= 1'b0;
    wait_sig(1, 1'b0, 20, n);
    $display("test edit done");
    extend_ms_in <= 16'h0001;
    watchdog_extend_instr_in <= 1'b1;
    @(posedge ref_clk_in);
    watchdog_extend_instr_in <= 1'b0;
    // the first ms tick falls inside this wait; the extension must carry it
    repeat (14960) @(posedge ref_clk_in);
    chk("extend_alarm", 24'h0, {23'h0, fatal_alarm_out});
    chk("extend_run", 24'h1, {23'h0, run_enable_out});
    chk("flag_short", 24'h0, {23'h0, cycle_time_error_flag_out});
    $display("test extend done");
    limit_ms_in <= 16'h0000;
    cycle_end_in <= 1'b1;
    @(posedge ref_clk_in);
    cycle_end_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk("end_run", 24'h0, {23'h0, run_enable_out});
    chk("last_ms", 24'h1, {8'h00, last_cycle_ms_out});
    wait_sig(2, 1'b1, 60000, n);
    chk("fatal_code", 24'h00009F, {16'h0000, fatal_code_out});
    chk("halt_run", 24'h0, {23'h0, run_enable_out});
    $display("test overrun done");
    print_verdict();
  end
endmodule : scw_top_test
